// *** rtl/urf_pkg.sv ***
package urf_pkg;
	// Oversampling tick indices (count starts at zero on the falling edge)
	localparam logic [3:0] HALF16_LAST = 4'h7;
	localparam logic [3:0] HALF8_LAST  = 4'h3;
	localparam logic [3:0] FULL16_LAST = 4'hF;
	localparam logic [3:0] FULL8_LAST  = 4'h7;

	// Receive queue geometry
	localparam int         FIFO_DEPTH = 64;
	localparam int         FIFO_WIDTH = 11;
	localparam int         LVL_W      = 7;
	localparam logic [6:0] DEPTH_LVL  = 7'h40;

	// Line status bit positions
	localparam int LSR_READY   = 0;
	localparam int LSR_OVERRUN = 1;
	localparam int LSR_ERR_LO  = 2;
	localparam int LSR_ERR_HI  = 4;

	// Interrupt flag bit positions
	localparam int ISR_READY   = 0;
	localparam int ISR_TIMEOUT = 1;
	localparam int ISR_XOFF    = 4;
	localparam int ISR_MODEM   = 5;

	// Interrupt enable bit positions
	localparam int IER_RX    = 0;
	localparam int IER_XOFF  = 5;
	localparam int IER_RTS   = 6;
	localparam int IER_CTS   = 7;

	// Timing in bit times and character counts
	localparam logic [6:0] TO_CHARS       = 7'h04;
	localparam logic [6:0] TO_EXTRA_BITS  = 7'h0C;
	localparam logic [6:0] MIN_WORD_BITS  = 7'h05;
	localparam logic [6:0] XOFF_DLY_CHARS = 7'h02;
	localparam logic [6:0] FRAME_OVERHEAD = 7'h02;

	// Software flow control modes and character slots
	localparam logic [1:0] SWF_OFF    = 2'h0;
	localparam logic [1:0] SWF_FIRST  = 2'h1;
	localparam logic [1:0] SWF_SECOND = 2'h2;
	localparam logic [1:0] SWF_PAIR   = 2'h3;
	localparam logic [1:0] SLOT_RES1  = 2'h0;
	localparam logic [1:0] SLOT_RES2  = 2'h1;
	localparam logic [1:0] SLOT_PAU1  = 2'h2;
	localparam logic [1:0] SLOT_PAU2  = 2'h3;
	localparam logic [7:0] CHAR_RESET = 8'h00;

	// Fixed trigger tables A..C, four levels each; table 3 is programmable
	localparam logic [1:0] TABLE_PROG = 2'h3;
	localparam logic [2:0][3:0][6:0] TRIG_TAB = {
		{7'h3C, 7'h38, 7'h10, 7'h08},
		{7'h1C, 7'h18, 7'h10, 7'h08},
		{7'h3C, 7'h38, 7'h10, 7'h08}};

	typedef enum logic [2:0] {
		URF_IDLE   = 3'b000,
		URF_START  = 3'b001,
		URF_DATA   = 3'b010,
		URF_PARITY = 3'b011,
		URF_STOP   = 3'b100
	} urf_state_t;
endpackage : urf_pkg

// *** rtl/urf_receiver.sv ***
// Function
// RULE_01 - Falling edge starts tick count; start bit sampled after 8 (4) ticks, kept if low.
// RULE_02 - Data and stop bits are sampled at their centres with the same counting.
// RULE_03 - Receive errors appear in line status bits 2 to 4.
// RULE_04 - Reading the holding register pops the queue and refreshes the error bits.
// RULE_05 - Unread data idle for four word lengths plus 12 bit times raises timeout.
// RULE_06 - Data ready per character or at trigger level, gated by enable bit 0.
// RULE_07 - Receive queue holds 64 entries of eight data bits plus three tags.
// RULE_08 - With queue enabled the holding register shows the oldest unread character.
// RULE_09 - Auto request-to-send enabled by feature bit 6, started by modem control bit 1.
// RULE_10 - Request-to-send rising sets status bit 5 when enabled and unlocked.
// RULE_11 - Auto mode raises request-to-send at upper limit, lowers it at lower limit.
// RULE_12 - Characters keep entering the queue after deassertion until it is full.
// RULE_13 - Tables A to C use the neighbouring trigger levels as hysteresis limits.
// RULE_14 - Auto clear-to-send holds the transmitter while the input is high.
// RULE_15 - Clear-to-send going high sets status bit 5 when enabled and unlocked.
// RULE_16 - A received pause match stops the transmitter after its current character.
// RULE_17 - Pause match sets flag and interrupt; resume match restarts and clears bit 4.
// RULE_18 - Reset clears all pause and resume characters to zero.
// RULE_19 - Pair mode compares two consecutive characters against both programmed values.
// RULE_20 - Matched flow control characters never enter the host queue.
// RULE_21 - Crossing trigger level sends pause characters after two character times.
// RULE_22 - Resume characters sent once the queue drains to the lower level.
// RULE_23 - One bit time is 16 oversampling ticks, or 8 in 8x mode.
// RULE_24 - Word length 5 to 8 bits governs reception, timeout and comparisons.
// RULE_25 - A start bit sampled high is discarded and the receiver returns idle.
// RULE_26 - Framing and parity errors are stored as tags with the byte.
`timescale 1ns/1ps

module urf_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 64
) (
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic      [WIDTH-1:0]           out_data,
	output logic      [$clog2(DEPTH):0]     level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	wire              do_wr = in_valid & in_ready;
	wire              do_rd = out_valid & out_ready;

	assign in_ready  = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			wr_ptr <= wr_ptr + AW'(do_wr);
			rd_ptr <= rd_ptr + AW'(do_rd);
			level  <= level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule : urf_fifo

module urf_receiver (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       os_tick,
	input  wire logic       rx,
	input  wire logic       cts_n,
	input  wire logic       sample_8x,
	input  wire logic [1:0] word_len,
	input  wire logic       parity_en,
	input  wire logic       parity_even,
	input  wire logic       fifo_en,
	input  wire logic [1:0] trig_table,
	input  wire logic [1:0] trig_sel,
	input  wire logic [6:0] trig_prog,
	input  wire logic [6:0] hyst_prog,
	input  wire logic       auto_rts_en,
	input  wire logic       auto_cts_en,
	input  wire logic       enh_unlock,
	input  wire logic       rts_on,
	input  wire logic [7:0] int_enable,
	input  wire logic [1:0] sw_flow_mode,
	input  wire logic       char_wr,
	input  wire logic [1:0] char_sel,
	input  wire logic [7:0] char_data,
	input  wire logic       rhr_rd,
	input  wire logic       lsr_rd,
	input  wire logic       isr_rd,
	input  wire logic       tx_ack,
	output logic      [7:0] receive_holding,
	output logic      [7:0] line_status,
	output logic      [7:0] isr_flags,
	output logic            irq,
	output logic            rts_n,
	output logic            tx_hold,
	output logic            xoff_req,
	output logic            xon_req,
	output logic      [6:0] rx_level
);
	urf_pkg::urf_state_t state;
	logic [3:0]  cnt, bdiv;
	logic [2:0]  bitn;
	logic [7:0]  shreg, resume_char_one, resume_char_two, pause_char_one, pause_char_two;
	logic [10:0] rx_word, pend_word, redo_word, out_d;
	logic [6:0]  to_cnt, dly_cnt, lvl;
	logic        par_bit, rx_prev, cts_prev, rx_done, pend, pend_off, pend_on, redo_v;
	logic        sw_paused, to_flag, xoff_wait, xoff_sent, fifo_rdy, out_v;

	// Bit timing and framing
	wire [3:0] half_last = sample_8x ? urf_pkg::HALF8_LAST : urf_pkg::HALF16_LAST;
	wire [3:0] full_last = sample_8x ? urf_pkg::FULL8_LAST : urf_pkg::FULL16_LAST; // RULE_23
	wire [2:0] wl_last   = {1'b1, word_len};
	wire       fall      = rx_prev & ~rx;
	wire       at_half   = os_tick & (cnt == half_last);
	wire       at_full   = os_tick & (cnt == full_last);
	wire       bit_tick  = os_tick & (bdiv == full_last);
	wire [7:0] aligned   = shreg >> (2'h3 - word_len);
	wire       pe        = parity_en & (^aligned ^ par_bit ^ ~parity_even);
	wire       fe        = ~rx;
	wire       bi        = ~rx & (aligned == 8'h00) & ~(parity_en & par_bit);
	wire [6:0] wl_bits   = urf_pkg::MIN_WORD_BITS + 7'(word_len);
	wire [6:0] to_lim    = 7'(urf_pkg::TO_CHARS * wl_bits) + urf_pkg::TO_EXTRA_BITS;
	wire [6:0] dly_lim   = 7'(urf_pkg::XOFF_DLY_CHARS * (wl_bits + urf_pkg::FRAME_OVERHEAD));

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state   <= urf_pkg::URF_IDLE;
			cnt     <= '0;
			bitn    <= '0;
			shreg   <= '0;
			par_bit <= 1'b0;
			rx_prev <= 1'b1;
			rx_done <= 1'b0;
			rx_word <= '0;
			bdiv    <= '0;
		end else begin
			rx_prev <= rx;
			rx_done <= 1'b0;
			bdiv    <= bit_tick ? 4'h0 : bdiv + 4'(os_tick);
			if (os_tick) begin
				cnt <= (at_full || (state == urf_pkg::URF_START && at_half)) ? 4'h0 : cnt + 4'h1;
			end
			unique case (state)
				urf_pkg::URF_IDLE: begin
					if (fall) begin
						state <= urf_pkg::URF_START; // RULE_01
						cnt   <= '0;
					end
				end
				urf_pkg::URF_START: begin
					if (at_half) begin
						state <= rx ? urf_pkg::URF_IDLE : urf_pkg::URF_DATA; // RULE_01 RULE_25
						bitn  <= '0;
					end
				end
				urf_pkg::URF_DATA: begin
					if (at_full) begin
						shreg <= {rx, shreg[7:1]}; // RULE_02
						bitn  <= bitn + 3'h1;
						if (bitn == wl_last) begin // RULE_24
							state <= parity_en ? urf_pkg::URF_PARITY : urf_pkg::URF_STOP;
						end
					end
				end
				urf_pkg::URF_PARITY: begin
					if (at_full) begin
						par_bit <= rx;
						state   <= urf_pkg::URF_STOP;
					end
				end
				urf_pkg::URF_STOP: begin
					if (at_full) begin
						rx_done <= 1'b1;
						rx_word <= {bi, fe, pe, aligned}; // RULE_26 RULE_02
						state   <= urf_pkg::URF_IDLE;
					end
				end
				default: state <= urf_pkg::URF_IDLE;
			endcase
		end
	end

	// Flow control character matching, masked to the word length
	wire [7:0]  wmask  = 8'hFF >> (2'h3 - word_len);
	wire        cv     = rx_done | redo_v;
	wire [10:0] cword  = redo_v ? redo_word : rx_word;
	wire        m_r1   = ((cword[7:0] ^ resume_char_one) & wmask) == 8'h00; // RULE_24
	wire        m_r2   = ((cword[7:0] ^ resume_char_two) & wmask) == 8'h00;
	wire        m_p1   = ((cword[7:0] ^ pause_char_one) & wmask) == 8'h00;
	wire        m_p2   = ((cword[7:0] ^ pause_char_two) & wmask) == 8'h00;
	wire        single = (sw_flow_mode == urf_pkg::SWF_FIRST) | (sw_flow_mode == urf_pkg::SWF_SECOND);
	wire        dbl    = (sw_flow_mode == urf_pkg::SWF_PAIR);
	wire        use1   = (sw_flow_mode == urf_pkg::SWF_FIRST);
	wire        s_on   = single & (use1 ? m_r1 : m_r2);
	wire        s_off  = single & (use1 ? m_p1 : m_p2);
	wire        d_first  = dbl & ~pend & (m_r1 | m_p1);
	wire        d_off    = dbl & pend & pend_off & m_p2; // A first character may open both pairs
	wire        d_on     = dbl & pend & pend_on & m_r2;
	wire        d_second = d_off | d_on; // RULE_19
	wire        mis_pend = cv & dbl & pend & ~d_second;
	wire        hit_off  = cv & (s_off | d_off);
	wire        hit_on   = cv & ((s_on & ~s_off) | (d_on & ~d_off));
	wire        push_v   = (cv & ~(s_on | s_off | d_first | d_second)) | mis_pend; // RULE_20
	wire [10:0] push_w   = mis_pend ? pend_word : cword;
	wire        accept   = fifo_en ? fifo_rdy : (lvl == 7'h00);
	wire        overrun  = push_v & ~accept;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resume_char_one <= urf_pkg::CHAR_RESET; // RULE_18
			resume_char_two <= urf_pkg::CHAR_RESET;
			pause_char_one  <= urf_pkg::CHAR_RESET;
			pause_char_two  <= urf_pkg::CHAR_RESET;
			pend            <= 1'b0;
			pend_off        <= 1'b0;
			pend_on         <= 1'b0;
			pend_word       <= '0;
			redo_v          <= 1'b0;
			redo_word       <= '0;
			sw_paused       <= 1'b0;
		end else begin
			if (char_wr && char_sel == urf_pkg::SLOT_RES1) resume_char_one <= char_data;
			if (char_wr && char_sel == urf_pkg::SLOT_RES2) resume_char_two <= char_data;
			if (char_wr && char_sel == urf_pkg::SLOT_PAU1) pause_char_one  <= char_data;
			if (char_wr && char_sel == urf_pkg::SLOT_PAU2) pause_char_two  <= char_data;
			// A broken pair replays the second character next cycle
			redo_v    <= mis_pend;
			redo_word <= cword;
			if (!dbl) begin
				pend <= 1'b0;
			end else if (cv) begin
				pend      <= d_first; // RULE_19
				pend_off  <= m_p1;
				pend_on   <= m_r1;
				pend_word <= cword;
			end
			if (hit_off) sw_paused <= 1'b1; // RULE_16
			else if (hit_on || sw_flow_mode == urf_pkg::SWF_OFF) sw_paused <= 1'b0; // RULE_17
		end
	end

	urf_fifo #(
		.WIDTH (urf_pkg::FIFO_WIDTH),
		.DEPTH (urf_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (push_v & accept), // RULE_12
		.in_ready  (fifo_rdy),
		.in_data   (push_w),
		.out_valid (out_v),
		.out_ready (rhr_rd), // RULE_04 RULE_08
		.out_data  (out_d),
		.level     (lvl)
	); // RULE_07
	// Trigger and hysteresis levels
	wire       is_prog = (trig_table == urf_pkg::TABLE_PROG);
	wire [1:0] tix     = is_prog ? 2'h0 : trig_table;
	wire [6:0] trig    = is_prog ? trig_prog : urf_pkg::TRIG_TAB[tix][trig_sel];
	wire [7:0] p_up    = {1'b0, trig_prog} + {1'b0, hyst_prog};
	wire [6:0] t_up    = (trig_sel == 2'h3) ? urf_pkg::DEPTH_LVL : urf_pkg::TRIG_TAB[tix][trig_sel + 2'h1];
	wire [6:0] t_lo    = (trig_sel == 2'h0) ? 7'h00 : urf_pkg::TRIG_TAB[tix][trig_sel - 2'h1];
	wire [6:0] upper   = is_prog ? ((p_up > 8'(urf_pkg::DEPTH_LVL)) ? urf_pkg::DEPTH_LVL : p_up[6:0])
		: t_up; // RULE_13
	wire [6:0] lower   = is_prog ? ((trig_prog > hyst_prog) ? trig_prog - hyst_prog : 7'h00) : t_lo; // RULE_13
	wire       rd_int  = int_enable[urf_pkg::IER_RX] & (fifo_en ? (lvl >= trig) : out_v); // RULE_06 RULE_11
	wire       to_int  = int_enable[urf_pkg::IER_RX] & to_flag;
	wire       next_rts_n = !rts_on ? 1'b1 : !auto_rts_en ? 1'b0 :
		(lvl >= upper) ? 1'b1 : (lvl <= lower) ? 1'b0 : rts_n; // RULE_09 RULE_11
	wire       rts_rise = ~rts_n & next_rts_n & int_enable[urf_pkg::IER_RTS] & enh_unlock; // RULE_10
	wire       cts_rise = cts_n & ~cts_prev & int_enable[urf_pkg::IER_CTS] & enh_unlock; // RULE_15
	wire       xoff_set = hit_off & int_enable[urf_pkg::IER_XOFF];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			to_cnt    <= '0;
			to_flag   <= 1'b0;
			xoff_wait <= 1'b0;
			xoff_sent <= 1'b0;
			dly_cnt   <= '0;
			xoff_req  <= 1'b0;
			xon_req   <= 1'b0;
			rts_n     <= 1'b1;
			cts_prev  <= 1'b1;
			tx_hold   <= 1'b0;
			isr_flags <= '0;
			irq       <= 1'b0;
			line_status     <= '0;
			receive_holding <= '0;
			rx_level  <= '0;
		end else begin
			// Timeout restarts on any character bound for the queue, on a host read, or while the queue is empty
			if (!out_v || push_v || rhr_rd) begin
				to_cnt  <= '0;
				to_flag <= 1'b0;
			end else if (bit_tick && !to_flag) begin
				to_cnt  <= to_cnt + 7'h01;
				to_flag <= (to_cnt + 7'h01 == to_lim); // RULE_05
			end
			if (sw_flow_mode == urf_pkg::SWF_OFF) begin
				xoff_wait <= 1'b0;
				xoff_sent <= 1'b0;
			end else if (!xoff_sent && !xoff_wait && lvl >= trig) begin
				xoff_wait <= 1'b1;
				dly_cnt   <= '0;
			end else if (xoff_wait && bit_tick) begin
				dly_cnt <= dly_cnt + 7'h01;
				if (dly_cnt + 7'h01 == dly_lim) begin
					xoff_wait <= 1'b0;
					xoff_sent <= 1'b1; // RULE_21
				end
			end else if (xoff_sent && lvl <= lower) begin
				xoff_sent <= 1'b0; // RULE_22
			end
			xoff_req <= (xoff_wait && bit_tick && dly_cnt + 7'h01 == dly_lim) | (xoff_req & ~tx_ack); // RULE_21
			xon_req  <= (xoff_sent && !xoff_wait && lvl <= lower && sw_flow_mode != urf_pkg::SWF_OFF)
				| (xon_req & ~tx_ack); // RULE_22
			rts_n    <= next_rts_n; // RULE_11
			cts_prev <= cts_n;
			tx_hold  <= (auto_cts_en & cts_n) | (sw_paused & ~hit_on) | hit_off; // RULE_14 RULE_16
			isr_flags[urf_pkg::ISR_READY]   <= rd_int;
			isr_flags[urf_pkg::ISR_TIMEOUT] <= to_int;
			// Set wins over a clear in the same cycle
			isr_flags[urf_pkg::ISR_XOFF]  <= xoff_set | (isr_flags[urf_pkg::ISR_XOFF] & ~hit_on); // RULE_17
			isr_flags[urf_pkg::ISR_MODEM] <= rts_rise | cts_rise | (isr_flags[urf_pkg::ISR_MODEM] & ~isr_rd);
			irq <= rd_int | to_int | xoff_set | rts_rise | cts_rise
				| (isr_flags[urf_pkg::ISR_XOFF] & ~hit_on) | (isr_flags[urf_pkg::ISR_MODEM] & ~isr_rd);
			receive_holding <= out_d[7:0]; // RULE_08
			line_status[urf_pkg::LSR_READY] <= out_v;
			line_status[urf_pkg::LSR_OVERRUN] <= overrun | (line_status[urf_pkg::LSR_OVERRUN] & ~lsr_rd);
			line_status[urf_pkg::LSR_ERR_HI:urf_pkg::LSR_ERR_LO] <= out_v ? out_d[10:8] : 3'h0; // RULE_03 RULE_04
			rx_level <= lvl;
		end
	end

	a_start_reject: assert property (@(posedge clk) disable iff (!reset_n) // RULE_25
		state == urf_pkg::URF_START && at_half && rx |=> state == urf_pkg::URF_IDLE) else $error("high start sample kept");
	a_start_accept: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
		state == urf_pkg::URF_START && at_half && !rx |=> state == urf_pkg::URF_DATA) else $error("low start sample lost");
	a_queue_bound: assert property (@(posedge clk) disable iff (!reset_n) // RULE_07
		lvl <= urf_pkg::DEPTH_LVL) else $error("queue level above depth");
	a_flow_consume: assert property (@(posedge clk) disable iff (!reset_n) // RULE_20
		(hit_on || hit_off) |-> !push_v) else $error("flow character pushed to queue");
	a_rts_upper: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
		rts_on && auto_rts_en && lvl >= upper |=> rts_n) else $error("request-to-send not raised at upper limit");
	a_rts_event: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
		$rose(rts_n) && $past(int_enable[urf_pkg::IER_RTS] & enh_unlock) |-> isr_flags[urf_pkg::ISR_MODEM])
		else $error("request-to-send rise not flagged");
	a_xoff_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE_16
		hit_off |=> tx_hold ##1 (tx_hold || $past(hit_on))) else $error("pause match did not hold transmitter");
	a_xon_clear: assert property (@(posedge clk) disable iff (!reset_n) // RULE_17
		hit_on && !xoff_set |=> !isr_flags[urf_pkg::ISR_XOFF]) else $error("resume match did not clear flag");
	a_head_tags: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
		$past(rhr_rd && out_v) && out_v |=> line_status[urf_pkg::LSR_ERR_HI:urf_pkg::LSR_ERR_LO] == $past(out_d[10:8]))
		else $error("error bits not refreshed after read");
	a_timeout_len: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
		$rose(to_flag) |-> to_cnt == to_lim) else $error("timeout raised at wrong count");
endmodule : urf_receiver

// *** sim/urf_remote_station.sv ***
`timescale 1ns/1ps

module urf_remote_station (
	input  wire logic clk,
	input  wire logic os_tick,
	input  wire logic sample_8x,
	output logic      rx
);
	initial rx = 1'b1;

	task automatic bit_out(input logic v);
		rx <= v;
		repeat (sample_8x ? 8 : 16) @(posedge clk iff os_tick);
	endtask : bit_out

	// Low par_ok or stop_ok sends a deliberately broken frame
	task automatic send_char(input logic [7:0] d, input int nbits, input logic par_en, input logic par_ok,
		input logic stop_ok);
		logic p;
		p = ~par_ok;
		@(posedge clk);
		bit_out(1'b0);
		for (int i = 0; i < nbits; i++) begin
			bit_out(d[i]);
			p ^= d[i];
		end
		if (par_en)
			bit_out(p);
		bit_out(stop_ok);
		// Idle bit so that a low stop bit never merges into the next start bit
		bit_out(1'b1);
	endtask : send_char

	task automatic false_start();
		@(posedge clk);
		rx <= 1'b0;
		repeat (2) @(posedge clk iff os_tick);
		rx <= 1'b1;
		repeat (32) @(posedge clk iff os_tick);
	endtask : false_start
endmodule : urf_remote_station

// *** sim/tb_uart_receiver_flow_control.sv ***
`timescale 1ns/1ps

module tb_uart_receiver_flow_control;
	logic       clk, reset_n, cts_n, sample_8x, parity_en, parity_even, fifo_en;
	logic       os_tick = 1'b0;
	logic       auto_rts_en, auto_cts_en, enh_unlock, rts_on, char_wr, rhr_rd, lsr_rd, isr_rd, tx_ack;
	logic [1:0] word_len, trig_table, trig_sel, sw_flow_mode, char_sel;
	logic [6:0] trig_prog, hyst_prog, rx_level;
	logic [7:0] int_enable, char_data, receive_holding, line_status, isr_flags;
	logic       irq, rts_n, tx_hold, xoff_req, xon_req;
	wire        rx;
	int         n_errors = 0;
	int         checked = 0;
	int         cyc = 0;

	urf_receiver uut (.clk, .reset_n, .os_tick, .rx, .cts_n, .sample_8x, .word_len, .parity_en, .parity_even,
		.fifo_en, .trig_table, .trig_sel, .trig_prog, .hyst_prog, .auto_rts_en, .auto_cts_en, .enh_unlock,
		.rts_on, .int_enable, .sw_flow_mode, .char_wr, .char_sel, .char_data, .rhr_rd, .lsr_rd, .isr_rd,
		.tx_ack, .receive_holding, .line_status, .isr_flags, .irq, .rts_n, .tx_hold, .xoff_req, .xon_req,
		.rx_level);
	urf_remote_station rs (.clk, .os_tick, .sample_8x, .rx);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Tick every second clock keeps a frame short
	always @(posedge clk) os_tick <= ~os_tick;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			results();
		end
	end

	task results();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic chkb(input logic g, input logic e);
		chk({7'h00, g}, {7'h00, e});
	endtask : chkb

	// Head is compared before the pop
	task automatic rd(input logic [7:0] e);
		chk(receive_holding, e);
		@(posedge clk);
		rhr_rd <= 1'b1;
		@(posedge clk);
		rhr_rd <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : rd

	task automatic snd(input logic [7:0] d);
		rs.send_char(d, 8, parity_en, 1'b1, 1'b1);
		repeat (2) @(posedge clk);
	endtask : snd

	initial begin
		{reset_n, sample_8x, parity_en, fifo_en, auto_rts_en, auto_cts_en, enh_unlock, rts_on} <= '0;
		{char_wr, rhr_rd, lsr_rd, isr_rd, tx_ack, cts_n, char_sel, trig_table, trig_sel, sw_flow_mode} <= '0;
		{trig_prog, hyst_prog, char_data} <= '0;
		parity_even <= 1'b1;
		word_len <= 2'h3;
		int_enable <= 8'h21;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk(line_status, 8'h00);
		chkb(rts_n, 1'b1);
		// Pause char one stays at its reset value
		char_sel <= 2'h3;
		char_data <= 8'h93;
		char_wr <= 1'b1;
		@(posedge clk);
		char_wr <= 1'b0;
		sw_flow_mode <= 2'h3;
		snd(8'h00);
		snd(8'h93);
		chkb(tx_hold, 1'b1);
		chkb(isr_flags[4], 1'b1);
		chk({1'b0, rx_level}, 8'h00);
		snd(8'h00);
		snd(8'h00);
		chkb(tx_hold, 1'b0);
		chkb(isr_flags[4], 1'b0);
		sw_flow_mode <= 2'h0;
		snd(8'hA5);
		chk(line_status, 8'h01);
		chkb(irq, 1'b1);
		rd(8'hA5);
		for (int w = 0; w < 3; w++) begin
			word_len <= w[1:0];
			rs.send_char(8'hFF, w + 5, 1'b0, 1'b1, 1'b1);
			repeat (2) @(posedge clk);
			rd(8'hFF >> (3 - w));
		end
		word_len <= 2'h3;
		rs.false_start();
		chkb(line_status[0], 1'b0);
		sample_8x <= 1'b1;
		snd(8'h3C);
		rd(8'h3C);
		sample_8x <= 1'b0;
		fifo_en <= 1'b1;
		parity_en <= 1'b1;
		rs.send_char(8'h55, 8, 1'b1, 1'b0, 1'b1);
		rs.send_char(8'hAA, 8, 1'b1, 1'b1, 1'b0);
		snd(8'h0F);
		rs.send_char(8'h00, 8, 1'b1, 1'b1, 1'b0);
		chk(line_status, 8'h05);
		rd(8'h55);
		chk(line_status, 8'h09);
		rd(8'hAA);
		chk(line_status, 8'h01);
		rd(8'h0F);
		chk(line_status, 8'h19);
		rd(8'h00);
		parity_en <= 1'b0;
		snd(8'h77);
		repeat (1280) @(posedge clk);
		chkb(isr_flags[1], 1'b0);
		repeat (256) @(posedge clk);
		chkb(isr_flags[1], 1'b1);
		rd(8'h77);
		trig_table <= 2'h1;
		{auto_rts_en, rts_on, enh_unlock} <= 3'h7;
		int_enable <= 8'hE1;
		sw_flow_mode <= 2'h1;
		repeat (3) @(posedge clk);
		chkb(rts_n, 1'b0);
		// The station ignores rts_n so the queue overfills
		for (int i = 0; i < 65; i++) begin
			snd(8'h40 + i[7:0]);
			if (i == 6) chkb(isr_flags[0], 1'b0);
			if (i == 7) chkb(isr_flags[0], 1'b1);
			if (i == 7) chkb(xoff_req, 1'b0);
			if (i == 14) chkb(rts_n, 1'b0);
			if (i == 15) chkb(rts_n, 1'b1);
			if (i == 15) chkb(isr_flags[5], 1'b1);
			if (i == 63) chk({1'b0, rx_level}, 8'h40);
			if (i == 11) begin
				chkb(xoff_req, 1'b1);
				tx_ack <= 1'b1;
				@(posedge clk);
				tx_ack <= 1'b0;
			end
		end
		chkb(line_status[1], 1'b1);
		lsr_rd <= 1'b1;
		@(posedge clk);
		lsr_rd <= 1'b0;
		isr_rd <= 1'b1;
		@(posedge clk);
		isr_rd <= 1'b0;
		repeat (3) @(posedge clk);
		chkb(isr_flags[5], 1'b0);
		{auto_cts_en, cts_n} <= 2'h3;
		repeat (4) @(posedge clk);
		chkb(line_status[1], 1'b0);
		chkb(isr_flags[5], 1'b1);
		chkb(tx_hold, 1'b1);
		cts_n <= 1'b0;
		repeat (4) @(posedge clk);
		chkb(tx_hold, 1'b0);
		for (int i = 0; i < 64; i++) rd(8'h40 + i[7:0]);
		chkb(rts_n, 1'b0);
		chkb(xon_req, 1'b1);
		results();
	end
endmodule : tb_uart_receiver_flow_control
